/* verilog/mto_map.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: currents in 0.01 A, frequency in 0.01 Hz, 32-bit bus words
// Notes:   shared by the thermal overload block only
`ifndef MTO_MAP_SVH
`define MTO_MAP_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define MTO_OFF_FIRST_RATED   8'h00
`define MTO_OFF_SECOND_RATED  8'h04
`define MTO_OFF_APPLIED_MOTOR 8'h08
`define MTO_OFF_SECOND_MOTOR  8'h0c
`define MTO_OFF_USER_GROUP    8'h10
`define MTO_OFF_CARRIER       8'h14
`define MTO_OFF_STATUS        8'h18

// ****************************************************************
// status fields
// ****************************************************************
`define MTO_ST_PREALARM       0
`define MTO_ST_MOTOR_TRIP     1
`define MTO_ST_TRANS_TRIP     2
`define MTO_ST_CONST_TORQUE   3
`define MTO_ST_SECOND_ACTIVE  4

// ****************************************************************
// values and reset values
// ****************************************************************
`define MTO_RATED_MAX         16'hc350
`define MTO_SETTING_INVALID   16'h270f
`define MTO_SECOND_RATED_RST  16'h270f
`define MTO_APPLIED_RST       16'h0000
`define MTO_SECOND_MOTOR_RST  16'h270f
`define MTO_USER_GROUP_RST    16'h0000
`define MTO_CARRIER_RST       16'h0001
`define MTO_CARRIER_MAX       16'h000f
`define MTO_SMALL_DEFAULT_PCT 32'h00000055
`define MTO_PREALARM_PCT      64'h0000000000000055
`define MTO_FULL_PCT          64'h0000000000000064

// ****************************************************************
// timing and thermal characteristic
// ****************************************************************
`define MTO_CLK_MHZ           25
`define MTO_TICK_US           1000
`define MTO_COOL_SHIFT        16
`define MTO_TRANS_SHIFT       12
`define MTO_FREQ_CT_MIN       16'h0258
`define MTO_FREQ_BAND2        16'h07d0
`define MTO_FREQ_BAND3        16'h0bb8
`define MTO_W_LOWEST          4'he
`define MTO_W_BAND2           4'hb
`define MTO_W_BAND3           4'h9
`define MTO_W_NOMINAL         4'h8
`define MTO_TRANS_W_BASE      5'h10
`define MTO_TRANS_LIMIT_NUM   64'h0000000000000009

`endif

/* verilog/mto_pkg.sv */
// Purpose: types of the thermal overload block
// Assumes: nothing beyond the map header
// Notes:   constants live in mto_map.svh
package mto_pkg;

    // integration mode of one motor accumulator
    typedef enum logic [1:0] {
        mode_off,
        mode_actual,
        mode_cool
    } mto_mode_e;

    typedef logic [15:0] mto_setting_t;

endpackage : mto_pkg

/* verilog/mto_thermal_overload.sv */
// Purpose: electronic thermal overload relay for one or two motors
// Assumes: current and frequency inputs are synchronous, 0.01 A and 0.01 Hz units
// Notes:   registers over AXI4-Lite; trips clear only by reset
//
// Overview of operation
// RULE_01: first rated current setting, 0 to 500 A, is motor one's reference.
// RULE_02: first setting zero disables motor one protection; transistor protection stays.
// RULE_03: second rated setting 0 to 500 A used with select on; 9999 invalid.
// RULE_04: select input on makes protection use the second rated setting.
// RULE_05: each accumulator integrates actual current, integrates zero current, or is off.
// RULE_06: motor one: off if zero, else actual/cool by select, 9999 pair always actual.
// RULE_07: motor two: actual with select, cool without; zero off; 9999 conditional.
// RULE_08: prealarm when active accumulator reaches 85 percent of its level.
// RULE_09: motor overload trip when accumulator reaches 100 percent of its level.
// RULE_10: thermal fault cleared only by power-on reset or reset input.
// RULE_11: first setting defaults to drive rating, 85 percent for small drives.
// RULE_12: motor codes 1, 13-16, 50, 53, 54 select constant-torque characteristic.
// RULE_13: applied motor defaults to 0, standard; only listed codes accepted.
// RULE_14: second motor select defaults 9999 meaning none; 0 or 1 choose characteristic.
// RULE_15: higher carrier setting shortens transistor protection operating time.
// RULE_16: second setting and motor selects writable only when user group is 0.
// RULE_17: constant-torque characteristic applies only at 6 Hz or above.
// RULE_18: operator should not set rated current at 5 percent of drive or less.
// RULE_19: accumulator integrates weighted current squared minus cooling per fixed table.
`timescale 1ns/1ps
`include "mto_map.svh"

module mto_thermal_overload #(
    parameter logic [15:0] DRIVE_RATED_CURRENT = 16'h01f4,
    parameter bit          SMALL_DRIVE         = 1'b0,
    parameter int          TICK_CYCLES         = `MTO_TICK_US * `MTO_CLK_MHZ
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [15:0] output_current,
    input  wire logic [15:0] output_frequency,
    input  wire logic        second_function_select,
    input  wire logic        fault_reset,
    output logic             thermal_prealarm,
    output logic             motor_overload_trip,
    output logic             transistor_overheat_trip,
    output logic             constant_torque_active
);

    // ****************************************************************
    // constants
    // ****************************************************************
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [31:0] SCALED_RATED =
        (32'(DRIVE_RATED_CURRENT) * `MTO_SMALL_DEFAULT_PCT) / 32'h00000064;
    localparam logic [15:0] FIRST_RATED_RST =
        SMALL_DRIVE ? SCALED_RATED[15:0] : DRIVE_RATED_CURRENT; // [RULE_11]
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    // ****************************************************************
    // functions
    // ****************************************************************
    // register index from address, 7 for unmapped
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        case (addr)
            `MTO_OFF_FIRST_RATED:   reg_index = 3'h0;
            `MTO_OFF_SECOND_RATED:  reg_index = 3'h1;
            `MTO_OFF_APPLIED_MOTOR: reg_index = 3'h2;
            `MTO_OFF_SECOND_MOTOR:  reg_index = 3'h3;
            `MTO_OFF_USER_GROUP:    reg_index = 3'h4;
            `MTO_OFF_CARRIER:       reg_index = 3'h5;
            `MTO_OFF_STATUS:        reg_index = 3'h6;
            default:                reg_index = 3'h7;
        endcase
    endfunction : reg_index

    // constant-torque motor codes
    function automatic logic is_const_torque(input logic [15:0] code);
        is_const_torque = (code == 16'h0001) || (code >= 16'h000d && code <= 16'h0010)
                       || (code == 16'h0032) || (code == 16'h0035)
                       || (code == 16'h0036); // [RULE_12]
    endfunction : is_const_torque

    // listed applied motor codes only
    function automatic logic applied_code_ok(input logic [15:0] code);
        applied_code_ok = (code == 16'h0000) || is_const_torque(code)
                       || (code >= 16'h0003 && code <= 16'h0006)
                       || (code == 16'h0017) || (code == 16'h0018)
                       || (code == 16'h0028) || (code == 16'h002b)
                       || (code == 16'h002c); // [RULE_13]
    endfunction : applied_code_ok

    // heating weight in eighths; slow standard motors cool poorly
    function automatic logic [3:0] heat_weight(input logic [15:0] freq, input logic ct);
        if (freq < `MTO_FREQ_CT_MIN) begin
            heat_weight = `MTO_W_LOWEST;
        end else if (ct) begin
            heat_weight = `MTO_W_NOMINAL; // [RULE_17]
        end else if (freq < `MTO_FREQ_BAND2) begin
            heat_weight = `MTO_W_BAND2;
        end else if (freq < `MTO_FREQ_BAND3) begin
            heat_weight = `MTO_W_BAND3;
        end else begin
            heat_weight = `MTO_W_NOMINAL; // [RULE_19]
        end
    endfunction : heat_weight

    // byte-lane merge into a 16-bit setting
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction : merge16

    // ****************************************************************
    // settings
    // ****************************************************************
    mto_pkg::mto_setting_t first_rated_motor_current;
    mto_pkg::mto_setting_t second_rated_motor_current;
    mto_pkg::mto_setting_t applied_motor_select;
    mto_pkg::mto_setting_t second_motor_select;
    mto_pkg::mto_setting_t user_group_read_select;
    mto_pkg::mto_setting_t carrier_frequency_select;

    // ****************************************************************
    // write channel decode
    // ****************************************************************
    logic [2:0]  wr_idx;
    logic [15:0] wr_old;
    logic [15:0] wr_val;
    logic        wr_group_ok;
    logic        wr_ok;
    logic        wr_take;

    assign wr_take = awvalid && wvalid && awready && wready;
    assign wr_idx  = reg_index(awaddr);
    assign wr_old  = (wr_idx == 3'h0) ? first_rated_motor_current :
                     (wr_idx == 3'h1) ? second_rated_motor_current :
                     (wr_idx == 3'h2) ? applied_motor_select :
                     (wr_idx == 3'h3) ? second_motor_select :
                     (wr_idx == 3'h4) ? user_group_read_select : carrier_frequency_select;
    assign wr_val  = merge16(wr_old, wdata, wstrb);
    assign wr_group_ok = (user_group_read_select == 16'h0000); // [RULE_16]
    assign wr_ok   = (wr_idx == 3'h0) ? (wr_val <= `MTO_RATED_MAX) : // [RULE_01]
                     (wr_idx == 3'h1) ? wr_group_ok && ((wr_val <= `MTO_RATED_MAX)
                                        || (wr_val == `MTO_SETTING_INVALID)) : // [RULE_03]
                     (wr_idx == 3'h2) ? wr_group_ok && applied_code_ok(wr_val) : // [RULE_13]
                     (wr_idx == 3'h3) ? wr_group_ok && ((wr_val == 16'h0000)
                                        || (wr_val == 16'h0001)
                                        || (wr_val == `MTO_SETTING_INVALID)) : // [RULE_14]
                     (wr_idx == 3'h4) ? 1'b1 :
                     (wr_idx == 3'h5) ? (wr_val <= `MTO_CARRIER_MAX) : 1'b0;

    // ****************************************************************
    // write channel
    // ****************************************************************
    // both channels accepted together; one write in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
        end else begin
            awready <= awvalid && wvalid && !awready && !bvalid;
            wready  <= awvalid && wvalid && !awready && !bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_take) begin
            bvalid <= 1'b1;
            bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_rated_motor_current  <= FIRST_RATED_RST; // [RULE_11]
            second_rated_motor_current <= `MTO_SECOND_RATED_RST; // [RULE_03]
            applied_motor_select       <= `MTO_APPLIED_RST; // [RULE_13]
            second_motor_select        <= `MTO_SECOND_MOTOR_RST; // [RULE_14]
            user_group_read_select     <= `MTO_USER_GROUP_RST;
            carrier_frequency_select   <= `MTO_CARRIER_RST;
        end else if (wr_take && wr_ok) begin
            case (wr_idx)
                3'h0:    first_rated_motor_current  <= wr_val;
                3'h1:    second_rated_motor_current <= wr_val;
                3'h2:    applied_motor_select       <= wr_val;
                3'h3:    second_motor_select        <= wr_val;
                3'h4:    user_group_read_select     <= wr_val;
                3'h5:    carrier_frequency_select   <= wr_val;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    logic [2:0]  rd_idx;
    logic [31:0] rd_data;
    logic [31:0] status_word;

    assign status_word = {27'h0000000, second_function_select, constant_torque_active,
                          transistor_overheat_trip, motor_overload_trip, thermal_prealarm};
    assign rd_idx  = reg_index(araddr);
    assign rd_data = (rd_idx == 3'h0) ? {16'h0000, first_rated_motor_current} :
                     (rd_idx == 3'h1) ? {16'h0000, second_rated_motor_current} :
                     (rd_idx == 3'h2) ? {16'h0000, applied_motor_select} :
                     (rd_idx == 3'h3) ? {16'h0000, second_motor_select} :
                     (rd_idx == 3'h4) ? {16'h0000, user_group_read_select} :
                     (rd_idx == 3'h5) ? {16'h0000, carrier_frequency_select} :
                     (rd_idx == 3'h6) ? status_word : 32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= arvalid && !arready && !rvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= rd_data;
                rresp  <= (rd_idx == 3'h7) ? RESP_SLVERR : RESP_OKAY;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // integration tick
    // ****************************************************************
    logic [31:0] tick_count;
    logic        tick;

    always_ff @(posedge aclk) begin
        if (!aresetn || tick_count == TICK_LAST) begin
            tick_count <= 32'h00000000;
        end else begin
            tick_count <= tick_count + 32'h00000001;
        end
    end
    assign tick = (tick_count == TICK_LAST);

    // ****************************************************************
    // accumulator modes and characteristic
    // ****************************************************************
    logic              first_zero;
    logic              second_invalid;
    logic              second_motor_none;
    logic              ct_first;
    logic              ct_second;
    logic              use_second;
    mto_pkg::mto_mode_e mode [2];

    assign first_zero        = (first_rated_motor_current == 16'h0000);
    assign second_invalid    = (second_rated_motor_current == `MTO_SETTING_INVALID);
    assign second_motor_none = (second_motor_select == `MTO_SETTING_INVALID);

    // motor one accumulator
    assign mode[0] = first_zero ? mto_pkg::mode_off : // [RULE_02]
                     (second_invalid && second_motor_none) ? mto_pkg::mode_actual :
                     second_function_select ? mto_pkg::mode_cool :
                     mto_pkg::mode_actual; // [RULE_06]

    // motor two accumulator
    assign mode[1] = (second_rated_motor_current == 16'h0000) ? mto_pkg::mode_off :
                     (second_invalid && (second_motor_none || first_zero)) ?
                         mto_pkg::mode_off :
                     second_function_select ? mto_pkg::mode_actual :
                     mto_pkg::mode_cool; // [RULE_07]

    // second level only where motor two integrates the actual current
    assign use_second = second_function_select && (mode[1] == mto_pkg::mode_actual); // [RULE_04]

    assign ct_first  = is_const_torque(applied_motor_select); // [RULE_12]
    assign ct_second = second_motor_none ? ct_first
                                         : (second_motor_select == 16'h0001); // [RULE_14]

    // 9999 second setting borrows the first level
    logic [15:0] rated [2];
    logic [3:0]  weight [2];
    assign rated[0]  = first_rated_motor_current; // [RULE_01]
    assign rated[1]  = second_invalid ? first_rated_motor_current
                                      : second_rated_motor_current;
    assign weight[0] = heat_weight(output_frequency, ct_first);
    assign weight[1] = heat_weight(output_frequency, ct_second);

    // ****************************************************************
    // motor accumulators
    // ****************************************************************
    logic [63:0] acc       [2];
    logic [63:0] next_acc  [2];
    logic [63:0] limit     [2];
    logic        reach_pre [2];
    logic        reach_top [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_motor
            logic [63:0] cur;
            logic [63:0] heat;

            assign cur  = (mode[g] == mto_pkg::mode_actual) ? 64'(output_current)
                                                            : 64'h0; // [RULE_05]
            assign heat = (cur * cur * 64'(weight[g])) >> 3;
            assign next_acc[g] = acc[g] + heat - (acc[g] >> `MTO_COOL_SHIFT); // [RULE_19]
            assign limit[g] = (64'(rated[g]) * 64'(rated[g])) << `MTO_COOL_SHIFT;
            assign reach_pre[g] = (acc[g] * `MTO_FULL_PCT)
                                  >= (limit[g] * `MTO_PREALARM_PCT); // [RULE_08]
            assign reach_top[g] = (mode[g] != mto_pkg::mode_off)
                                  && (acc[g] >= limit[g]); // [RULE_09]

            // reset input restarts the thermal history as well
            always_ff @(posedge aclk) begin
                if (!aresetn || fault_reset || mode[g] == mto_pkg::mode_off) begin
                    acc[g] <= 64'h0; // [RULE_10]
                end else if (tick) begin
                    acc[g] <= next_acc[g];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // transistor accumulator
    // ****************************************************************
    logic [63:0] trans_acc;
    logic [63:0] trans_heat;
    logic [63:0] trans_limit;
    logic [4:0]  trans_weight;

    // weight in sixteenths grows with carrier setting
    assign trans_weight = `MTO_TRANS_W_BASE + carrier_frequency_select[4:0]; // [RULE_15]
    assign trans_heat   = (64'(output_current) * 64'(output_current)
                           * 64'(trans_weight)) >> 4;
    assign trans_limit  = ((64'(DRIVE_RATED_CURRENT) * 64'(DRIVE_RATED_CURRENT)
                           * `MTO_TRANS_LIMIT_NUM) >> 2) << `MTO_TRANS_SHIFT;

    always_ff @(posedge aclk) begin
        if (!aresetn || fault_reset) begin
            trans_acc <= 64'h0;
        end else if (tick) begin
            trans_acc <= trans_acc + trans_heat
                         - (trans_acc >> `MTO_TRANS_SHIFT); // [RULE_02]
        end
    end

    // ****************************************************************
    // indications and trips
    // ****************************************************************
    logic active_pre;
    assign active_pre = use_second ? reach_pre[1]
                                   : (mode[0] != mto_pkg::mode_off) && reach_pre[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thermal_prealarm       <= 1'b0;
            constant_torque_active <= 1'b0;
        end else begin
            thermal_prealarm       <= active_pre; // [RULE_08]
            constant_torque_active <= (use_second ? ct_second : ct_first)
                                      && (output_frequency >= `MTO_FREQ_CT_MIN); // [RULE_17]
        end
    end

    // latched; a new overload wins over nothing, only reset clears
    always_ff @(posedge aclk) begin
        if (!aresetn || fault_reset) begin
            motor_overload_trip      <= 1'b0; // [RULE_10]
            transistor_overheat_trip <= 1'b0;
        end else begin
            if (reach_top[0] || reach_top[1]) begin
                motor_overload_trip <= 1'b1; // [RULE_09]
            end
            if (trans_acc >= trans_limit) begin
                transistor_overheat_trip <= 1'b1; // [RULE_15]
            end
        end
    end

endmodule : mto_thermal_overload

/* testbench/mto_properties.sv */
// Purpose: port checks of the thermal overload block. Assumes: one clock. Notes: bound below.
`timescale 1ns/1ps
module mto_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [15:0] output_frequency,
    input wire logic        fault_reset,
    input wire logic        motor_overload_trip,
    input wire logic        constant_torque_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // below the constant-torque floor
    wire logic slow_freq = output_frequency < 16'h0258;
    sequence wr_taken; awvalid && awready; endsequence
    chk_write_resp: assert property (wr_taken |=> bvalid) else $error("no write response");
    chk_read_data: assert property (arvalid && arready |=> rvalid) else $error("no read data");
    chk_resp_drop: assert property (bvalid && bready |=> !bvalid) else $error("bvalid stuck");
    chk_data_drop: assert property (rvalid && rready |=> !rvalid) else $error("rvalid stuck");
    chk_ready_pair: assert property (awready |-> wready) else $error("ready split");
    chk_aw_pulse: assert property (awready |=> !awready) else $error("awready long");
    chk_trip_hold: assert property (motor_overload_trip && !fault_reset |=> motor_overload_trip)
        else $error("trip dropped");
    chk_trip_clear: assert property (fault_reset |=> !motor_overload_trip)
        else $error("trip kept");
    chk_ct_floor: assert property (slow_freq [*2] |-> !constant_torque_active)
        else $error("torque curve low");
endmodule : mto_properties
bind mto_thermal_overload mto_properties chk_u (.*);

/* testbench/mto_drive_model.sv */
// Purpose: power stage stand-in. Assumes: bench requests after an edge. Notes: motor overload trip cuts output.
`timescale 1ns/1ps
module mto_drive_model (
    input  wire logic        aclk,
    input  wire logic [15:0] cur_req,
    input  wire logic        clr_req,
    input  wire logic        motor_overload_trip,
    output logic      [15:0] output_current = 16'h0000,
    output logic             fault_reset    = 1'b0
);
    always @(posedge aclk) begin
        output_current <= motor_overload_trip ? 16'h0000 : cur_req;
        fault_reset    <= clr_req; // only on request, resets spoil the heat estimate
    end
endmodule : mto_drive_model

/* testbench/tb_motor_thermal_overload.sv */
// Purpose: self-checking bench. Assumes: model drives current. Notes: queued expectations.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; exp_v = (e); if ((g) !== exp_v) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), exp_v); end end
module tb_motor_thermal_overload;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, second_function_select = 1'b0, clr_req = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, fault_reset, thermal_prealarm;
    logic        motor_overload_trip, transistor_overheat_trip, constant_torque_active;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000, rdata, r;
    logic [15:0] cur_req = 16'h0000, output_frequency = 16'h0000, output_current;
    logic [1:0]  bresp, rresp, wq[$];
    logic [33:0] exp_v, rq[$];
    logic [3:0]  wstrb = 4'h3;
    logic [15:0] rst_v[4] = '{16'h01f4, 16'h270f, 16'h0000, 16'h270f};
    logic [15:0] codes[9] = '{16'h0001, 16'h000d, 16'h000e, 16'h000f, 16'h0010, 16'h0032,
                              16'h0035, 16'h0036, 16'h0000};
    int          num_errors = 0, n_checks = 0, i;
    always #20 aclk = ~aclk;
    mto_thermal_overload #(.TICK_CYCLES(4)) dut_u (.*);
    mto_drive_model model_u (.*);
    always @(posedge aclk) begin
        if (bvalid && bready) `CHK(bresp, wq.pop_front())
        if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front())
    end
    task automatic end_sim();
        $display("errors=%0d checks=%0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // one bus cycle, write when w is high; answer checked by the monitor
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                        input logic [1:0] e);
        int n;
        repeat (2) @(posedge aclk);
        if (w) wq.push_back(e);
        else rq.push_back({e, 16'h0000, d});
        {awaddr, araddr, wdata} <= {a, a, 16'h0000, d};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if (w ? bvalid : rvalid) break;
        end
        {bready, rready} <= 2'b00;
        num_errors += int'(n == 50);
        if (n == 50) end_sim();
    endtask : xfer
    initial begin
        r = $urandom(10);
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 4; i++) xfer(0, 8'(4 * i), rst_v[i], 2'b00);
        xfer(0, 8'h1c, 16'h0000, 2'b10);
        xfer(1, 8'h00, 16'hc351, 2'b10);
        r = $urandom % 32'h0000c351;
        xfer(1, 8'h00, r[15:0], 2'b00);
        xfer(0, 8'h00, r[15:0], 2'b00);
        for (i = 0; i < 9; i++) xfer(1, 8'h08, codes[i], 2'b00);
        xfer(1, 8'h08, 16'h0002, 2'b10);
        output_frequency <= 16'h03e8;
        xfer(1, 8'h08, 16'h0001, 2'b00);
        xfer(0, 8'h18, 16'h0008, 2'b00);
        output_frequency <= 16'h0257;
        xfer(0, 8'h18, 16'h0000, 2'b00);
        xfer(1, 8'h00, 16'hc350, 2'b00);
        xfer(1, 8'h04, 16'h0064, 2'b00);
        xfer(1, 8'h10, 16'h0001, 2'b00);
        xfer(1, 8'h04, 16'h0032, 2'b10);
        output_frequency <= 16'h1770;
        second_function_select <= 1'b1;
        cur_req <= 16'h03e8;
        for (i = 0; i < 20000 && motor_overload_trip !== 1'b1; i++) @(posedge aclk);
        `CHK(motor_overload_trip, 1'b1)
        `CHK({thermal_prealarm, constant_torque_active, transistor_overheat_trip}, 3'b110)
        if (i == 20000) end_sim();
        xfer(0, 8'h18, 16'h001b, 2'b00);
        {cur_req, clr_req} <= {16'h0000, 1'b1};
        repeat (3) @(posedge aclk);
        clr_req <= 1'b0;
        xfer(0, 8'h18, 16'h0018, 2'b00);
        // motor one against 500 A never trips here, so only the power stage trips
        second_function_select <= 1'b0;
        xfer(1, 8'h14, 16'h000f, 2'b00);
        cur_req <= 16'h03e8;
        for (i = 0; i < 20000 && transistor_overheat_trip !== 1'b1; i++) @(posedge aclk);
        `CHK({transistor_overheat_trip, motor_overload_trip}, 2'b10)
        end_sim();
    end
endmodule : tb_motor_thermal_overload
